// File: cnt_pkg.sv
// constants, field layout and apb map of the bcd up/down counter
// assumes a 100 MHz clk_i with every input synchronous to it
// How it works
// R1: clear low forces all four counter digits to zero.
// R2: clear also empties the display latch only when the strobe is low.
// R3: clear drives zero on the shared bus, so a coinciding compare load stores zero.
// R4: outside party waits 5 ms after compare load before asserting clear.
// R5: carry pulse on 9999 to 0000 counting up and 0000 to 9999 down.
// R6: outside party chains carry into a second counter's count input.
// R7: zero flag low whenever the live count is zero, latch ignored.
// R8: zero flag invalid while counter load is high and 5 ms after.
// R9: equal flag low whenever live count matches the compare register.
// R10: equal flag invalid while either load is high and 5 ms after.
// R11: with scan pin floating, digits scan from the internal 2500 Hz rate.
// R12: external scan advances the digit scan on each rising edge.
// R13: digit drives enabled only while external scan is low.
// R14: during any load, scan pin ignored and internal 8 kHz rate used.
// R15: blank select at middle level enables leading-zero blanking.
// R16: blank select low shows every digit.
// R17: blank select high turns segments off; bcd and digit outputs stay.
// R18: strobe low shows live count; strobe rising captures count into latch.
// R19: count edge steps count by direction unless clear, counter load or the 5 ms after it, or run bit off.
// R20: scan walks digits from thousands down to units.
// R21: leading-zero blanking hides zero digits above the top nonzero digit.
package cnt_pkg;
  // ****************
  // timing
  // ****************
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned SCAN_HZ       = 2500;
  localparam int unsigned LOAD_SCAN_HZ  = 8000;
  localparam int unsigned GUARD_MS      = 5;
  localparam int unsigned CARRY_NS      = 1000;
  localparam int unsigned SCAN_CYC      = CLK_HZ / SCAN_HZ;
  localparam int unsigned LOAD_SCAN_CYC = CLK_HZ / LOAD_SCAN_HZ;
  localparam int unsigned GUARD_CYC     = GUARD_MS * (CLK_HZ / 1000);
  localparam int unsigned CARRY_CYC     = CARRY_NS / CLK_NS;
  localparam int          DIV_W         = 20;
  // ****************
  // apb map
  // ****************
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  STAT_OFS   = 8'h04;
  localparam logic [7:0]  COUNT_OFS  = 8'h08;
  localparam logic [7:0]  LATCH_OFS  = 8'h0C;
  localparam logic [7:0]  CMP_OFS    = 8'h10;
  localparam logic        RUN_RST    = 1'b1;
  localparam int          RUN_BIT    = 0;
  // ****************
  // values
  // ****************
  localparam logic [1:0]  BLANK_NONE = 2'h0;
  localparam logic [1:0]  BLANK_LZ   = 2'h1;
  localparam logic [1:0]  BLANK_ALL  = 2'h2;
  localparam logic [3:0]  DIGIT_RST  = 4'h0;
  localparam logic [3:0]  DIGIT_LAST = 4'h9;
  localparam logic [1:0]  TOP_DIGIT  = 2'h3;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'h9999;

  typedef enum logic {LD_IDLE, LD_SEQ} ld_state_e;
endpackage : cnt_pkg

// File: digit_if.sv
// one bcd stage's control and value
// assumes one controller and one stage per instance
`timescale 1ns/1ps
interface digit_if;
  logic       inc;
  logic       dec;
  logic       load;
  logic [3:0] ld_val;
  logic [3:0] val;
  modport ctl   (output inc, output dec, output load, output ld_val, input val);
  modport stage (input inc, input dec, input load, input ld_val, output val);
endinterface : digit_if

// File: bcd_digit.sv
// a single decade stage of the counter
// assumes the controller gives at most one of inc and dec at a time
`timescale 1ns/1ps
module bcd_digit
  import cnt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // stage control
  digit_if.stage   dig
);
  logic [3:0] val_ff;
  logic [3:0] nxt_val;
  wire  [3:0] up_w = (val_ff == DIGIT_LAST) ? 4'h0 : val_ff + 4'h1;
  wire  [3:0] dn_w = (val_ff == 4'h0) ? DIGIT_LAST : val_ff - 4'h1;

  // load wins: clear and preset both arrive as a load
  assign nxt_val = dig.load ? dig.ld_val : dig.inc ? up_w : dig.dec ? dn_w : val_ff;
  assign dig.val = val_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      val_ff <= DIGIT_RST;
    end else begin
      val_ff <= nxt_val;
    end
  end
endmodule : bcd_digit

// File: cnt_scan_top.sv
// counter core, display scan, flags and apb registers
// assumes all pins already synchronous to clk_i; three-level pins arrive decoded
`timescale 1ns/1ps
module cnt_scan_top
  import cnt_pkg::*;
#(
  parameter int unsigned SCAN_DIV  = SCAN_CYC,
  parameter int unsigned LOAD_DIV  = LOAD_SCAN_CYC,
  parameter int unsigned GUARD_DIV = GUARD_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // counter pins
  input  wire logic        count_i,
  input  wire logic        up_i,
  input  wire logic        clear_n_i,
  input  wire logic        store_i,
  input  wire logic        load_cnt_i,
  input  wire logic        load_reg_i,
  input  wire logic [3:0]  bcd_in_i,
  // display control pins
  input  wire logic        scan_i,
  input  wire logic        scan_ext_i,
  input  wire logic [1:0]  blank_sel_i,
  // flags
  output logic             carry_o,
  output logic             zero_n_o,
  output logic             equal_n_o,
  output logic             zero_valid_o,
  output logic             equal_valid_o,
  // display drive
  output logic      [3:0]  digit_o,
  output logic      [6:0]  seg_o,
  output logic      [3:0]  bcd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************
  // edge detect
  // ****************
  logic count_d_ff;
  logic scan_d_ff;
  logic store_d_ff;
  logic ldc_d_ff;
  logic ldr_d_ff;
  wire  count_rise = count_i & ~count_d_ff;
  wire  scan_rise  = scan_i & ~scan_d_ff;
  wire  store_rise = store_i & ~store_d_ff;
  wire  ldc_rise   = load_cnt_i & ~ldc_d_ff;
  wire  ldr_rise   = load_reg_i & ~ldr_d_ff;
  wire  ld_start   = ldc_rise | ldr_rise;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_d_ff <= 1'b0;
      scan_d_ff  <= 1'b0;
      store_d_ff <= 1'b0;
      ldc_d_ff   <= 1'b0;
      ldr_d_ff   <= 1'b0;
    end else begin
      count_d_ff <= count_i;
      scan_d_ff  <= scan_i;
      store_d_ff <= store_i;
      ldc_d_ff   <= load_cnt_i;
      ldr_d_ff   <= load_reg_i;
    end
  end

  // ****************
  // load guard windows
  // ****************
  // reloaded while the pin is high, so the window runs out GUARD_DIV after it falls
  logic [DIV_W-1:0] ldc_guard_ff;
  logic [DIV_W-1:0] ldr_guard_ff;
  wire  cnt_busy = load_cnt_i | (ldc_guard_ff != '0);
  wire  reg_busy = load_reg_i | (ldr_guard_ff != '0);
  wire  any_busy = cnt_busy | reg_busy;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ldc_guard_ff <= '0;
      ldr_guard_ff <= '0;
    end else begin
      ldc_guard_ff <= load_cnt_i ? DIV_W'(GUARD_DIV) : (cnt_busy ? ldc_guard_ff - 1'b1 : '0);
      ldr_guard_ff <= load_reg_i ? DIV_W'(GUARD_DIV) : (reg_busy ? ldr_guard_ff - 1'b1 : '0);
    end
  end

  // ****************
  // scan timing
  // ****************
  logic [DIV_W-1:0] div_ff;
  logic [1:0]       idx_ff;
  wire  [DIV_W-1:0] div_end  = any_busy ? DIV_W'(LOAD_DIV - 1) : DIV_W'(SCAN_DIV - 1); // R14 R11
  wire              int_tick = (div_ff >= div_end);
  // the pin is ignored for the whole load window, not just the sequence
  wire              mux_tick = (any_busy | ~scan_ext_i) ? int_tick : scan_rise; // R12 R14

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_ff <= '0;
      idx_ff <= TOP_DIGIT;
    end else begin
      div_ff <= (ld_start | int_tick) ? '0 : div_ff + 1'b1;
      if (ld_start) begin
        idx_ff <= TOP_DIGIT;
      end else if (mux_tick) begin
        idx_ff <= idx_ff - 2'h1; // R20
      end
    end
  end

  a_scan_order: assert property (mux_tick && !ld_start |=> idx_ff == 2'($past(idx_ff) - 2'h1)) // R20
    else $error("scan did not step down one digit");
  a_scan_ignore: assert property (any_busy && !int_tick && !ld_start |=> $stable(idx_ff)) // R14
    else $error("scan moved without internal tick during load");

  // ****************
  // load sequence
  // ****************
  ld_state_e seq_ff;
  logic      seq_cnt_ff;
  logic      seq_reg_ff;
  wire       cap_w  = (seq_ff == LD_SEQ) & mux_tick & ~ld_start;
  wire [3:0] bus_w  = clear_n_i ? bcd_in_i : 4'h0; // R3

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_ff     <= LD_IDLE;
      seq_cnt_ff <= 1'b0;
      seq_reg_ff <= 1'b0;
    end else begin
      case (seq_ff)
        LD_IDLE: begin
          if (ld_start) begin
            seq_ff     <= LD_SEQ;
            seq_cnt_ff <= ldc_rise;
            seq_reg_ff <= ldr_rise;
          end
        end
        LD_SEQ: begin
          if (ld_start) begin
            seq_cnt_ff <= seq_cnt_ff | ldc_rise;
            seq_reg_ff <= seq_reg_ff | ldr_rise;
          end else if (cap_w && idx_ff == 2'h0) begin
            seq_ff <= LD_IDLE;
          end
        end
        default: seq_ff <= LD_IDLE;
      endcase
    end
  end

  // ****************
  // counter stages
  // ****************
  digit_if   stage_if[4] ();
  logic      run_ff;
  wire [15:0] count_w;
  wire [4:0] low9;
  wire [4:0] low0;
  wire       step_ok = count_rise & clear_n_i & ~cnt_busy & run_ff; // R19
  wire       up_evt  = step_ok & up_i;
  wire       dn_evt  = step_ok & ~up_i;
  assign low9[0] = 1'b1;
  assign low0[0] = 1'b1;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dig
      assign count_w[4*g +: 4]  = stage_if[g].val;
      assign low9[g+1]          = low9[g] & (stage_if[g].val == DIGIT_LAST);
      assign low0[g+1]          = low0[g] & (stage_if[g].val == 4'h0);
      assign stage_if[g].inc    = up_evt & low9[g]; // R19
      assign stage_if[g].dec    = dn_evt & low0[g]; // R19
      // clear is a preset of every stage from the zeroed bus
      assign stage_if[g].load   = ~clear_n_i | (cap_w & seq_cnt_ff & (idx_ff == 2'(g))); // R1 R3
      assign stage_if[g].ld_val = bus_w;
      bcd_digit u_dig (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .dig   (stage_if[g])
      );
    end
  endgenerate

  a_clear_zero: assert property (!clear_n_i |=> count_w == COUNT_ZERO) // R1
    else $error("clear did not zero the counter");
  a_count_hold: assert property (count_rise && cnt_busy && clear_n_i && !cap_w |=> $stable(count_w)) // R19
    else $error("counter moved during counter load");

  // ****************
  // compare register and latch
  // ****************
  logic [15:0] cmp_ff;
  logic [15:0] latch_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_ff   <= COUNT_ZERO;
      latch_ff <= COUNT_ZERO;
    end else begin
      if (cap_w && seq_reg_ff) begin
        cmp_ff[{idx_ff, 2'b00} +: 4] <= bus_w; // R3
      end
      if (!clear_n_i && !store_i) begin
        latch_ff <= COUNT_ZERO; // R2
      end else if (store_rise) begin
        latch_ff <= count_w; // R18
      end
    end
  end

  a_latch_clear: assert property (!clear_n_i && !store_i |=> latch_ff == COUNT_ZERO) // R2
    else $error("latch not cleared by clear with strobe low");
  a_latch_keep: assert property (store_i && store_d_ff |=> $stable(latch_ff)) // R2
    else $error("latch changed while strobe held high");
  a_clear_cmp: assert property (cap_w && seq_reg_ff && !clear_n_i && idx_ff == 2'h3 |=> cmp_ff[15:12] == 4'h0) // R3
    else $error("clear during compare load did not store zero");

  // ****************
  // carry and flags
  // ****************
  logic [7:0] carry_cnt_ff;
  logic       carry_ff;
  logic       zero_n_ff;
  logic       equal_n_ff;
  logic       zero_valid_ff;
  logic       equal_valid_ff;
  wire        wrap = (up_evt & (count_w == COUNT_MAX)) | (dn_evt & (count_w == COUNT_ZERO)); // R5

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      carry_cnt_ff   <= 8'h00;
      carry_ff       <= 1'b0;
      zero_n_ff      <= 1'b0;
      equal_n_ff     <= 1'b0;
      zero_valid_ff  <= 1'b0;
      equal_valid_ff <= 1'b0;
    end else begin
      carry_cnt_ff   <= wrap ? 8'(CARRY_CYC - 1) : (carry_cnt_ff != 8'h00 ? carry_cnt_ff - 8'h01 : 8'h00);
      carry_ff       <= wrap | (carry_cnt_ff != 8'h00); // R5
      zero_n_ff      <= (count_w != COUNT_ZERO); // R7
      equal_n_ff     <= (count_w != cmp_ff); // R9
      zero_valid_ff  <= ~cnt_busy; // R8
      equal_valid_ff <= ~any_busy; // R10
    end
  end

  a_carry_start: assert property (wrap |=> carry_ff) // R5
    else $error("no carry pulse on wrap");
  a_carry_cause: assert property ($rose(carry_ff) |-> $past(wrap)) // R5
    else $error("carry pulse without wrap");
  a_zero_flag: assert property (1'b1 |=> zero_n_ff == ($past(count_w) != COUNT_ZERO)) // R7
    else $error("zero flag disagrees with count");
  a_equal_flag: assert property (1'b1 |=> equal_n_ff == ($past(count_w) != $past(cmp_ff))) // R9
    else $error("equal flag disagrees with compare");
  a_zero_invalid: assert property (load_cnt_i |=> !zero_valid_ff [*2]) // R8
    else $error("zero flag valid during counter load");
  a_equal_invalid: assert property (load_reg_i || load_cnt_i |=> !equal_valid_ff) // R10
    else $error("equal flag valid during a load");

  // ****************
  // display drive
  // ****************
  logic [3:0] digit_ff;
  logic [6:0] seg_ff;
  logic [3:0] bcd_ff;
  wire  [15:0] disp_w = store_i ? latch_ff : count_w; // R18
  wire  [3:0]  cur_w  = disp_w[{idx_ff, 2'b00} +: 4];
  wire  [3:0]  zdig;
  wire  [3:0]  lead;
  wire         dig_en = ~(scan_ext_i & ~any_busy & scan_i); // R13
  wire         lz_hit = (blank_sel_i == BLANK_LZ) & lead[idx_ff]; // R15 R21 R16
  wire         seg_on = (blank_sel_i != BLANK_ALL) & ~lz_hit; // R17

  generate
    for (g = 0; g < 4; g++) begin : g_lz
      assign zdig[g] = (disp_w[4*g +: 4] == 4'h0);
      assign lead[g] = &zdig[3:g]; // R21
    end
  endgenerate

  // segment order {g,f,e,d,c,b,a}, high lights a segment
  function automatic logic [6:0] seg7(input logic [3:0] v);
    case (v)
      4'h0: seg7 = 7'h3F;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5B;
      4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6D;
      4'h6: seg7 = 7'h7D;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;
      4'h9: seg7 = 7'h6F;
      default: seg7 = 7'h00;
    endcase
  endfunction : seg7

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      digit_ff <= 4'h0;
      seg_ff   <= 7'h00;
      bcd_ff   <= 4'h0;
    end else begin
      digit_ff <= dig_en ? (4'h1 << idx_ff) : 4'h0; // R13
      seg_ff   <= seg_on ? seg7(cur_w) : 7'h00; // R17
      bcd_ff   <= cur_w; // R17
    end
  end

  a_digit_gate: assert property (scan_ext_i && !any_busy && scan_i |=> digit_o == 4'h0) // R13
    else $error("digit driven while scan high");
  a_blank_all: assert property (blank_sel_i == BLANK_ALL |=> seg_o == 7'h00 && bcd_o == $past(cur_w)) // R17
    else $error("segments lit while blanked");
  a_show_all: assert property (blank_sel_i == BLANK_NONE && cur_w == 4'h0 |=> seg_o == 7'h3F) // R16
    else $error("zero digit blanked with blanking off");

  // ****************
  // apb registers
  // ****************
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_w;
  logic        hit_w;
  wire         setup_w = psel_i & ~penable_i;
  wire         wr_w    = psel_i & penable_i & pready_ff & pwrite_i & (paddr_i == CTRL_OFS);
  wire  [31:0] stat_w  = {26'h0, reg_busy, cnt_busy, equal_valid_ff, zero_valid_ff, ~equal_n_ff, ~zero_n_ff};

  always_comb begin
    hit_w = 1'b1;
    if (paddr_i == CTRL_OFS) begin
      rd_w = {31'h0, run_ff};
    end else if (paddr_i == STAT_OFS) begin
      rd_w = stat_w;
    end else if (paddr_i == COUNT_OFS) begin
      rd_w = {16'h0, count_w};
    end else if (paddr_i == LATCH_OFS) begin
      rd_w = {16'h0, latch_ff};
    end else if (paddr_i == CMP_OFS) begin
      rd_w = {16'h0, cmp_ff};
    end else begin
      rd_w  = 32'h0;
      hit_w = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
      run_ff     <= RUN_RST;
    end else begin
      pready_ff <= setup_w;
      if (setup_w) begin
        prdata_ff  <= pwrite_i ? 32'h0 : rd_w;
        pslverr_ff <= ~hit_w;
      end
      if (wr_w) begin
        run_ff <= pwdata_i[RUN_BIT];
      end
    end
  end

  // ****************
  // outputs
  // ****************
  assign prdata_o      = prdata_ff;
  assign pready_o      = pready_ff;
  assign pslverr_o     = pslverr_ff;
  assign carry_o       = carry_ff;
  assign zero_n_o      = zero_n_ff;
  assign equal_n_o     = equal_n_ff;
  assign zero_valid_o  = zero_valid_ff;
  assign equal_valid_o = equal_valid_ff;
  assign digit_o       = digit_ff;
  assign seg_o         = seg_ff;
  assign bcd_o         = bcd_ff;
endmodule : cnt_scan_top

// File: far_parts.sv
// far-side parts: thumbwheel switches strobed by the digit drives and a cascaded upper counter
// assumes one-hot active-high digit drives, bit 3 = thousands, all on clk_i
`timescale 1ns/1ps
module far_parts (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // from the counter
  input  wire logic [3:0]  digit_i,
  input  wire logic        carry_i,
  // switch setting
  input  wire logic [15:0] sw_i,
  // to the counter and the bench
  output logic      [3:0]  bcd_o,
  output logic      [15:0] upper_o
);
  // ****************
  // switches
  // ****************
  // unselected switches float; the bcd lines have pull-downs
  assign bcd_o = digit_i[3] ? sw_i[15:12] :
                 digit_i[2] ? sw_i[11:8]  :
                 digit_i[1] ? sw_i[7:4]   :
                 digit_i[0] ? sw_i[3:0]   : 4'h0;
  // ****************
  // upper counter
  // ****************
  logic carry_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      carry_ff <= 1'b0;
      upper_o  <= 16'h0000;
    end else begin
      carry_ff <= carry_i;
      if (carry_i && !carry_ff) begin
        upper_o <= upper_o + 16'h0001;
      end
    end
  end
endmodule : far_parts

// File: bcd_updown_counter_status_scan_bench.sv
// self-checking bench for the bcd up/down counter with scan and flags
// assumes cnt_scan_top with short divider parameters and far_parts on its pins
`timescale 1ns/1ps
module bcd_updown_counter_status_scan_bench
  import cnt_pkg::*;
;
  // ****************
  // signals
  // ****************
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  paddr;
  logic        psel, penable, pwrite;
  logic [31:0] pwdata, prdata_o;
  logic        pready_o, pslverr_o;
  logic        count_i, up_i, clear_n_i, store_i, load_cnt_i, load_reg_i;
  logic        scan_i, scan_ext_i;
  logic [1:0]  blank_sel_i;
  logic [3:0]  bcd_in, digit_o, bcd_o;
  logic [6:0]  seg_o;
  logic        carry_o, zero_n_o, equal_n_o, zero_valid_o, equal_valid_o;
  logic [15:0] sw, upper;
  int          n_errors = 0;
  int          samples_checked = 0;

  always #5 clk_i = ~clk_i;

  cnt_scan_top #(.SCAN_DIV(8), .LOAD_DIV(4), .GUARD_DIV(20)) cnt_scan_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .count_i(count_i), .up_i(up_i), .clear_n_i(clear_n_i),
    .store_i(store_i), .load_cnt_i(load_cnt_i), .load_reg_i(load_reg_i), .bcd_in_i(bcd_in),
    .scan_i(scan_i), .scan_ext_i(scan_ext_i), .blank_sel_i(blank_sel_i), .carry_o(carry_o),
    .zero_n_o(zero_n_o), .equal_n_o(equal_n_o), .zero_valid_o(zero_valid_o),
    .equal_valid_o(equal_valid_o), .digit_o(digit_o), .seg_o(seg_o), .bcd_o(bcd_o));

  far_parts far_parts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .digit_i(digit_o), .carry_i(carry_o),
    .sw_i(sw), .bcd_o(bcd_in), .upper_o(upper));

  // ****************
  // tasks
  // ****************
  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic hang(input string what);
    n_errors++;
    $display("[FAIL] %s expected done seen timeout", what);
    report_and_stop();
  endtask : hang

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // one apb read; waits for pready under a bound
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err, input string what);
    int n;
    paddr   <= a;
    pwrite  <= 1'b0;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) hang("pready");
    chk(what, exp, prdata_o);
    chk_bit("pslverr", err, pslverr_o);
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle cycle so a following call never re-raises psel in the same step
    @(posedge clk_i);
  endtask : rd_chk

  // one apb write; lands at the edge where pready is seen high
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    paddr   <= a;
    pwrite  <= 1'b1;
    pwdata  <= v;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) hang("pready");
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic step(input logic dir, input int n);
    repeat (n) begin
      up_i    <= dir;
      count_i <= 1'b1;
      tick(2);
      count_i <= 1'b0;
      tick(2);
    end
  endtask : step

  task automatic wait_valid();
    int n;
    n = 0;
    while (!(zero_valid_o === 1'b1 && equal_valid_o === 1'b1) && n < 200) begin
      tick(1);
      n++;
    end
    if (zero_valid_o !== 1'b1 || equal_valid_o !== 1'b1) hang("valid");
  endtask : wait_valid

  task automatic wait_digit(input logic [3:0] d);
    int n;
    n = 0;
    while (digit_o !== d && n < 40) begin
      tick(1);
      n++;
    end
    if (digit_o !== d) hang("digit");
  endtask : wait_digit

  // ****************
  // sequence
  // ****************
  logic [6:0] s_top [3] = '{7'h3F, 7'h00, 7'h00};
  logic [6:0] s_ten [3] = '{7'h06, 7'h06, 7'h00};
  logic [3:0] seq   [4] = '{4'h4, 4'h2, 4'h1, 4'h8};
  logic [3:0] d;
  int         n;

  initial begin
    paddr = 8'h00; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; pwdata = 32'h0;
    count_i = 1'b0; up_i = 1'b1; clear_n_i = 1'b1; store_i = 1'b0; load_cnt_i = 1'b0;
    load_reg_i = 1'b0; scan_i = 1'b0; scan_ext_i = 1'b0; blank_sel_i = BLANK_NONE; sw = 16'h1234;
    tick(6);
    rst_i <= 1'b0;
    rd_chk(CTRL_OFS, 32'h1, 1'b0, "ctrl");
    // run off must swallow count edges
    wr(CTRL_OFS, 32'h0);
    rd_chk(CTRL_OFS, 32'h0, 1'b0, "ctrl");
    step(1'b1, 1);
    rd_chk(COUNT_OFS, 32'h0, 1'b0, "count");
    wr(CTRL_OFS, 32'h1);
    chk_bit("zero_n", 1'b0, zero_n_o);
    chk_bit("equal_n", 1'b0, equal_n_o);
    rd_chk(8'h20, 32'h0, 1'b1, "unmapped");
    step(1'b1, 3);
    step(1'b0, 1);
    rd_chk(COUNT_OFS, 32'h2, 1'b0, "count");
    chk_bit("zero_n", 1'b1, zero_n_o);
    store_i <= 1'b1;
    tick(2);
    rd_chk(LATCH_OFS, 32'h2, 1'b0, "latch");
    clear_n_i <= 1'b0;
    step(1'b1, 2);
    clear_n_i <= 1'b1;
    tick(2);
    rd_chk(COUNT_OFS, 32'h0, 1'b0, "count");
    rd_chk(LATCH_OFS, 32'h2, 1'b0, "latch");
    store_i   <= 1'b0;
    clear_n_i <= 1'b0;
    tick(2);
    clear_n_i <= 1'b1;
    tick(2);
    rd_chk(LATCH_OFS, 32'h0, 1'b0, "latch");
    step(1'b0, 1);
    chk_bit("carry", 1'b1, carry_o);
    rd_chk(COUNT_OFS, 32'h9999, 1'b0, "count");
    tick(110);
    chk_bit("carry", 1'b0, carry_o);
    step(1'b1, 1);
    chk_bit("carry", 1'b1, carry_o);
    tick(110);
    chk("upper", 32'h2, 32'(upper));
    // compare load on the internal scan rate
    load_reg_i <= 1'b1;
    tick(2);
    chk_bit("equal_valid", 1'b0, equal_valid_o);
    chk_bit("zero_valid", 1'b1, zero_valid_o);
    load_reg_i <= 1'b0;
    wait_valid();
    rd_chk(CMP_OFS, 32'h1234, 1'b0, "cmp");
    chk_bit("equal_n", 1'b1, equal_n_o);
    // counter load with scan held: only the internal rate can advance digits
    scan_ext_i <= 1'b1;
    load_cnt_i <= 1'b1;
    tick(2);
    chk_bit("zero_valid", 1'b0, zero_valid_o);
    // a count edge inside the load window must be ignored
    step(1'b1, 1);
    load_cnt_i <= 1'b0;
    wait_valid();
    rd_chk(COUNT_OFS, 32'h1234, 1'b0, "count");
    chk_bit("equal_n", 1'b0, equal_n_o);
    // clear during a compare load breaks the 5 ms guard on purpose
    clear_n_i  <= 1'b0;
    load_reg_i <= 1'b1;
    tick(2);
    load_reg_i <= 1'b0;
    wait_valid();
    clear_n_i <= 1'b1;
    tick(2);
    rd_chk(CMP_OFS, 32'h0, 1'b0, "cmp");
    chk_bit("zero_n", 1'b0, zero_n_o);
    chk_bit("equal_n", 1'b0, equal_n_o);
    sw         <= 16'h0012;
    scan_ext_i <= 1'b0;
    load_cnt_i <= 1'b1;
    tick(2);
    load_cnt_i <= 1'b0;
    wait_valid();
    for (int i = 0; i < 3; i++) begin
      blank_sel_i <= 2'(i);
      tick(2);
      wait_digit(4'h8);
      chk("seg_top", 32'(s_top[i]), 32'(seg_o));
      chk("bcd_top", 32'h0, 32'(bcd_o));
      wait_digit(4'h2);
      chk("seg_ten", 32'(s_ten[i]), 32'(seg_o));
      chk("bcd_ten", 32'h1, 32'(bcd_o));
    end
    wait_digit(4'h8);
    for (int i = 0; i < 4; i++) begin
      n = 0;
      d = digit_o;
      while (digit_o === d && n < 12) begin
        tick(1);
        n++;
      end
      chk("digit", 32'(seq[i]), 32'(digit_o));
      chk("scan_period", 32'h8, 32'(n));
    end
    scan_ext_i <= 1'b1;
    tick(3);
    d = digit_o;
    tick(30);
    chk("digit", 32'(d), 32'(digit_o));
    scan_i <= 1'b1;
    tick(3);
    chk("digit", 32'h0, 32'(digit_o));
    scan_i <= 1'b0;
    tick(3);
    chk("digit", 32'({d[0], d[3:1]}), 32'(digit_o));
    report_and_stop();
  end
endmodule : bcd_updown_counter_status_scan_bench
